// [rtl/four_level_irq_ctrl.sv]
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module four_level_irq_ctrl
    import irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic external_request0_pin,
    input wire logic external_request1_pin,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic serial_req,
    input wire logic irq_ack,
    input wire logic irq_ret,
    output logic irq_req,
    output logic [SRC_W-1:0] irq_src,
    output logic [LVL_W-1:0] irq_lvl,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [1:0] ext_meta_ff;
    logic [1:0] ext_sync_ff;
    logic [N_SRC-1:0] src_w;
    logic [7:0] ena_ff;
    logic [7:0] prh_ff;
    logic [7:0] ipl_ff;
    wire [N_SRC-1:0] pend_w;
    wire [N_SRC*LVL_W-1:0] lvl_w;
    wire [N_SRC-1:0] hi_w;
    wire [N_SRC-1:0] tie_w;
    logic [N_LVL-1:0] svc_ff;
    logic [N_LVL-1:0] nxt_svc;
    logic svc_any_w;
    logic [LVL_W-1:0] cur_lvl_w;
    logic grant_w;
    logic ack_w;
    logic irq_req_ff;
    logic [SRC_W-1:0] irq_src_ff;
    logic [LVL_W-1:0] irq_lvl_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic wr_go_w;
    logic wr_hit_w;
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_w;
    logic rd_hit_w;

    prio_arb_if arb ();

    // ************************************************************
    // Request sources
    // ************************************************************

    // Two-flop synchroniser for the external pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_meta_ff <= 2'h0;
            ext_sync_ff <= 2'h0;
        end else begin
            ext_meta_ff <= {external_request1_pin, external_request0_pin};
            ext_sync_ff <= ext_meta_ff;
        end
    end

    // Source vector in enable-bit order
    always_comb begin
        src_w = '0;
        src_w[SRC_EXT0] = ext_sync_ff[0];
        src_w[SRC_TMR0] = timer0_ovf;
        src_w[SRC_EXT1] = ext_sync_ff[1];
        src_w[SRC_TMR1] = timer1_ovf;
        src_w[SRC_SER] = serial_req;
        src_w[SRC_TMR2] = timer2_ovf;
    end

    // Per-source gating, level and ranking helpers
    for (genvar g = 0; g < N_SRC; g++) begin : g_src
        assign pend_w[g] = src_w[g] && ena_ff[g] && ena_ff[GIE_BIT];
        assign lvl_w[g*LVL_W +: LVL_W] = {prh_ff[g], ipl_ff[g]};
        assign hi_w[g] = pend_w[g] && (lvl_w[g*LVL_W +: LVL_W] > arb.win_lvl);
        assign tie_w[g] = pend_w[g] && (lvl_w[g*LVL_W +: LVL_W] == arb.win_lvl)
                          && (SRC_W'(g) < arb.win_src);
    end

    assign arb.pend = pend_w;
    assign arb.lvl = lvl_w;

    prio_resolver u_resolver (
        .arb (arb)
    );

    // ************************************************************
    // Preemption against the level in service
    // ************************************************************

    // Highest level currently in service
    always_comb begin
        svc_any_w = |svc_ff;
        cur_lvl_w = 2'h0;
        for (int i = 0; i < N_LVL; i++) begin
            if (svc_ff[i]) begin
                cur_lvl_w = LVL_W'(i);
            end
        end
    end

    // Grant only above the running level; level 3 blocks all
    always_comb begin
        grant_w = arb.win_valid && (!svc_any_w || arb.win_lvl > cur_lvl_w);
        ack_w = irq_ack && irq_req_ff;
    end

    // Request toward the core, dropped on acknowledge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_req_ff <= 1'b0;
            irq_src_ff <= SRC_EXT0;
            irq_lvl_ff <= 2'h0;
        end else begin
            irq_req_ff <= grant_w && !ack_w;
            irq_src_ff <= arb.win_src;
            irq_lvl_ff <= arb.win_lvl;
        end
    end

    // In-service stack: return pops, acknowledge pushes
    always_comb begin
        nxt_svc = svc_ff;
        if (irq_ret && svc_any_w) begin
            nxt_svc[cur_lvl_w] = 1'b0;
        end
        if (ack_w) begin
            nxt_svc[irq_lvl_ff] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            svc_ff <= '0;
        end else begin
            svc_ff <= nxt_svc;
        end
    end

    // ************************************************************
    // AXI4-Lite write path
    // ************************************************************

    // Write address capture
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awready_ff <= 1'b1;
            waddr_ff <= '0;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            waddr_ff <= s_axi_awaddr;
        end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
        end
    end

    // Write data capture, low byte lane only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wready_ff <= 1'b1;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
        end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
        end
    end

    // Both halves held and no response pending
    always_comb begin
        wr_go_w = !awready_ff && !wready_ff && !bvalid_ff;
        wr_hit_w = (waddr_ff == ENA_ADDR) || (waddr_ff == PRH_ADDR)
                   || (waddr_ff == IPL_ADDR) || (waddr_ff == STAT_ADDR);
    end

    // Write response
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_go_w) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit_w ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Enable and priority registers; reserved bits never stored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ena_ff <= ENA_RST;
            prh_ff <= PRIO_RST;
            ipl_ff <= PRIO_RST;
        end else if (wr_go_w && wstrb0_ff) begin
            unique case (waddr_ff)
                ENA_ADDR: ena_ff <= wdata_ff & ENA_WMASK;
                PRH_ADDR: prh_ff <= wdata_ff & PRIO_WMASK;
                IPL_ADDR: ipl_ff <= wdata_ff & PRIO_WMASK;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // AXI4-Lite read path
    // ************************************************************

    // Read data mux
    always_comb begin
        rd_w = 32'h0000_0000;
        rd_hit_w = 1'b1;
        unique case (s_axi_araddr)
            ENA_ADDR: rd_w[7:0] = ena_ff;
            PRH_ADDR: rd_w[7:0] = prh_ff;
            IPL_ADDR: rd_w[7:0] = ipl_ff;
            STAT_ADDR: rd_w[7:0] = {irq_req_ff, irq_src_ff, svc_ff};
            default: rd_hit_w = 1'b0;
        endcase
    end

    // Read handshake and response
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= rd_w;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign irq_req = irq_req_ff;
    assign irq_src = irq_src_ff;
    assign irq_lvl = irq_lvl_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    pin_sync_a: assert property (
        !$past(rst) && !$past(rst, 2) |-> src_w[SRC_EXT0] == $past(external_request0_pin, 2))
        else $error("external pin not seen two cycles later");

    own_enable_a: assert property (
        !ena_ff[SRC_EXT0] |=> !(irq_req_ff && irq_src_ff == SRC_EXT0))
        else $error("disabled source requested");

    global_off_a: assert property (
        !ena_ff[GIE_BIT] |=> !irq_req_ff)
        else $error("request while global enable clear");

    bit_map_a: assert property (
        !ena_ff[SRC_TMR2] ##1 !ena_ff[SRC_TMR2] |-> !(irq_req_ff && irq_src_ff == SRC_TMR2))
        else $error("timer 2 requested with bit 5 clear");

    level_map_a: assert property (
        $rose(irq_req_ff) && irq_src_ff == SRC_SER
        |-> irq_lvl_ff == $past({prh_ff[SRC_SER], ipl_ff[SRC_SER]}))
        else $error("serial level not taken from priority bits");

    preempt_only_a: assert property (
        irq_req_ff && $past(svc_any_w) |-> irq_lvl_ff > $past(cur_lvl_w))
        else $error("request not above level in service");

    top_block_a: assert property (
        svc_ff[LVL_TOP] |=> !irq_req_ff)
        else $error("request during top level service");

    higher_wins_a: assert property (
        arb.win_valid |-> hi_w == 6'h00)
        else $error("higher level pending but not chosen");

    poll_order_a: assert property (
        arb.win_valid |-> tie_w == 6'h00)
        else $error("polling order violated");

    rsvd_read_a: assert property (
        s_axi_arvalid && arready_ff && s_axi_araddr == ENA_ADDR |=> rvalid_ff && !rdata_ff[6])
        else $error("reserved enable bit read as one");

    ena_reset_a: assert property (
        $past(rst) |-> ena_ff == ENA_RST)
        else $error("enable register not cleared by reset");

    preempt_c: cover property (irq_req_ff && svc_any_w && ack_w);
    tie_c: cover property (arb.win_valid && $countones(pend_w) > 1 && hi_w == 6'h00);
    wr_err_c: cover property (bvalid_ff && bresp_ff == RESP_SLVERR);
    top_svc_c: cover property (svc_ff[LVL_TOP] && arb.win_valid);

endmodule
`default_nettype wire

// [rtl/irq_pkg.sv]
package irq_pkg;

    // ************************************************************
    // Register indices and bus addresses
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [7:0] ENA_IDX = 8'ha8;
    localparam logic [7:0] PRH_IDX = 8'hb7;
    localparam logic [7:0] IPL_IDX = 8'hb8;
    localparam logic [7:0] STAT_IDX = 8'hc0;
    localparam logic [ADDR_W-1:0] ENA_ADDR = {2'h0, ENA_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] PRH_ADDR = {2'h0, PRH_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IPL_ADDR = {2'h0, IPL_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int N_SRC = 6;
    localparam int SRC_W = 3;
    localparam int LVL_W = 2;
    localparam int N_LVL = 4;
    localparam int GIE_BIT = 7;
    localparam logic [SRC_W-1:0] SRC_EXT0 = 3'h0;
    localparam logic [SRC_W-1:0] SRC_TMR0 = 3'h1;
    localparam logic [SRC_W-1:0] SRC_EXT1 = 3'h2;
    localparam logic [SRC_W-1:0] SRC_TMR1 = 3'h3;
    localparam logic [SRC_W-1:0] SRC_SER = 3'h4;
    localparam logic [SRC_W-1:0] SRC_TMR2 = 3'h5;
    localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;
    localparam logic [7:0] ENA_WMASK = 8'hbf;
    localparam logic [7:0] PRIO_WMASK = 8'h3f;

    // ************************************************************
    // Reset values and bus responses
    // ************************************************************
    localparam logic [7:0] ENA_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rtl/prio_arb_if.sv]
`timescale 1ns/1ns
`default_nettype none
// Pending vector and levels in, winning source out
interface prio_arb_if;
    import irq_pkg::*;
    logic [N_SRC-1:0] pend;
    logic [N_SRC*LVL_W-1:0] lvl;
    logic win_valid;
    logic [SRC_W-1:0] win_src;
    logic [LVL_W-1:0] win_lvl;
    modport resolver (input pend, input lvl, output win_valid, output win_src, output win_lvl);
    modport ctrl (output pend, output lvl, input win_valid, input win_src, input win_lvl);
endinterface
`default_nettype wire

// [rtl/prio_resolver.sv]
`timescale 1ns/1ns
`default_nettype none
module prio_resolver
    import irq_pkg::*;
(
    prio_arb_if.resolver arb
);

    // ************************************************************
    // Highest level wins, lowest source index breaks ties
    // ************************************************************
    always_comb begin
        arb.win_valid = 1'b0;
        arb.win_src = SRC_EXT0;
        arb.win_lvl = 2'h0;
        // Scan downward so a lower index replaces an equal level
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (arb.pend[i] && (!arb.win_valid || arb.lvl[i*LVL_W +: LVL_W] >= arb.win_lvl)) begin
                arb.win_valid = 1'b1;
                arb.win_src = SRC_W'(i);
                arb.win_lvl = arb.lvl[i*LVL_W +: LVL_W];
            end
        end
    end

endmodule
`default_nettype wire

// [test/core_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Core side: acknowledges offered requests and returns on command
module core_model
    import irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic irq_req,
    input wire logic [SRC_W-1:0] irq_src,
    input wire logic [LVL_W-1:0] irq_lvl,
    input wire logic ack_en,
    input wire logic [1:0] ack_dly,
    input wire logic ret_cmd,
    output logic irq_ack,
    output logic irq_ret,
    output logic [SRC_W-1:0] acked_src,
    output logic [LVL_W-1:0] acked_lvl,
    output logic [7:0] ack_cnt
);
    logic [1:0] wait_ff;

    // Ack pulse after a chosen delay, counted only while the request stands
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_ack <= 1'b0;
            wait_ff <= 2'h0;
            acked_src <= '0;
            acked_lvl <= '0;
            ack_cnt <= 8'h00;
        end else begin
            irq_ack <= 1'b0;
            if (irq_ack && irq_req) begin
                acked_src <= irq_src;
                acked_lvl <= irq_lvl;
                ack_cnt <= ack_cnt + 8'h01;
            end else if (ack_en && irq_req && !irq_ack) begin
                if (wait_ff == ack_dly) begin
                    irq_ack <= 1'b1;
                    wait_ff <= 2'h0;
                end else begin
                    wait_ff <= wait_ff + 2'h1;
                end
            end
        end
    end

    // Return follows ret_cmd one cycle later
    always_ff @(posedge sys_clk) begin
        irq_ret <= rst ? 1'b0 : ret_cmd;
    end
endmodule
`default_nettype wire

// [test/four_level_interrupt_controller_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module four_level_interrupt_controller_tb;
    import irq_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] flg = 6'h00;
    logic ack_en = 1'b0;
    logic [1:0] ack_dly = 2'h0;
    logic ret_cmd = 1'b0;
    logic irq_ack, irq_ret, irq_req;
    logic [SRC_W-1:0] irq_src, acked_src;
    logic [LVL_W-1:0] irq_lvl, acked_lvl;
    logic [7:0] ack_cnt;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;

    // ************************************************************
    // Clock, design and core model
    // ************************************************************
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    four_level_irq_ctrl i_four_level_irq_ctrl (.sys_clk(sys_clk), .rst(rst),
        .external_request0_pin(flg[0]), .timer0_ovf(flg[1]), .external_request1_pin(flg[2]),
        .timer1_ovf(flg[3]), .serial_req(flg[4]), .timer2_ovf(flg[5]),
        .irq_ack(irq_ack), .irq_ret(irq_ret), .irq_req(irq_req), .irq_src(irq_src),
        .irq_lvl(irq_lvl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    core_model i_core_model (.sys_clk(sys_clk), .rst(rst), .irq_req(irq_req),
        .irq_src(irq_src), .irq_lvl(irq_lvl), .ack_en(ack_en), .ack_dly(ack_dly),
        .ret_cmd(ret_cmd), .irq_ack(irq_ack), .irq_ret(irq_ret), .acked_src(acked_src),
        .acked_lvl(acked_lvl), .ack_cnt(ack_cnt));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Write: address and data offered together, response awaited
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "bresp");
    endtask

    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic set_flg(input logic [5:0] v);
        @(posedge sys_clk);
        flg <= v;
    endtask

    // Expected winner: highest level, then lowest source index
    function automatic logic [5:0] exp_win(input logic [5:0] f, input logic [7:0] ena,
                                           input logic [7:0] prh, input logic [7:0] ipl);
        logic [5:0] w;
        w = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (f[i] && ena[i] && ena[7] && (!w[5] || {prh[i], ipl[i]} > w[1:0])) begin
                w = {1'b1, i[2:0], prh[i], ipl[i]};
            end
        end
        return w;
    endfunction

    task automatic run_arb(input logic [5:0] f, input logic [7:0] ena, input logic [7:0] prh,
                           input logic [7:0] ipl);
        logic [5:0] w;
        w = exp_win(f, ena, prh, ipl);
        axi_wr(ENA_ADDR, ena & ENA_WMASK);
        axi_wr(PRH_ADDR, prh & PRIO_WMASK);
        axi_wr(IPL_ADDR, ipl & PRIO_WMASK);
        set_flg(f);
        wait_cyc(5);
        chk({31'h0, irq_req}, {31'h0, w[5]}, "irq_req");
        if (w[5]) begin
            chk({29'h0, irq_src}, {29'h0, w[4:2]}, "irq_src");
            chk({30'h0, irq_lvl}, {30'h0, w[1:0]}, "irq_lvl");
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] v;
        logic [7:0] n0;
        void'($urandom(63224));
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        wait_cyc(1);
        // Reset values, read-back, strobe, read-only and unmapped address
        axi_rd(ENA_ADDR, d, r);
        chk(d & 32'hbf, 32'h0, "enable reset");
        axi_rd(PRH_ADDR, d, r);
        chk(d & 32'h3f, 32'h0, "prio high reset");
        v = 8'($urandom());
        axi_wr(IPL_ADDR, v & PRIO_WMASK);
        axi_rd(IPL_ADDR, d, r);
        chk(d & 32'h3f, {24'h0, v & 8'h3f}, "ipl readback");
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "read resp");
        wstrb <= 4'he;
        axi_wr(IPL_ADDR, ~v & PRIO_WMASK);
        wstrb <= 4'hf;
        axi_wr(STAT_ADDR, 8'hff);
        axi_rd(IPL_ADDR, d, r);
        chk(d & 32'h3f, {24'h0, v & 8'h3f}, "strobe off write");
        axi_rd(12'h004, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped resp");
        $display("test registers done");
        // Corner cases then random arbitration
        run_arb(6'h3f, 8'h3f, 8'h00, 8'h00);
        run_arb(6'h3f, 8'hbf, 8'h3f, 8'h3f);
        run_arb(6'h3f, 8'hbe, 8'h00, 8'h20);
        for (int k = 0; k < 80; k++) begin
            run_arb(6'($urandom()), 8'($urandom()), 8'($urandom()), 8'($urandom()));
        end
        set_flg(6'h00);
        $display("test arbitration done");
        // Preemption against the level in service
        axi_wr(ENA_ADDR, 8'h8a);
        for (int l = 0; l < 4; l++) begin
            for (int m = 0; m < 4; m++) begin
                axi_wr(PRH_ADDR, {4'h0, m[1], 1'b0, l[1], 1'b0});
                axi_wr(IPL_ADDR, {4'h0, m[0], 1'b0, l[0], 1'b0});
                n0 = ack_cnt;
                ack_dly <= 2'($urandom());
                ack_en <= 1'b1;
                set_flg(6'h02);
                while (ack_cnt == n0) wait_cyc(1);
                ack_en <= 1'b0;
                chk({29'h0, acked_src}, {29'h0, SRC_TMR0}, "acked src");
                chk({30'h0, acked_lvl}, l, "acked lvl");
                axi_rd(STAT_ADDR, d, r);
                chk({24'h0, d[7:0]}, {24'h0, 1'b0, SRC_TMR0, 4'h1 << l}, "status");
                set_flg(6'h08);
                wait_cyc(5);
                chk({31'h0, irq_req}, {31'h0, m > l}, "preempt");
                @(posedge sys_clk);
                ret_cmd <= 1'b1;
                @(posedge sys_clk);
                ret_cmd <= 1'b0;
                wait_cyc(5);
                chk({31'h0, irq_req}, 32'h1, "after return");
                chk({29'h0, irq_src}, {29'h0, SRC_TMR1}, "after return src");
                set_flg(6'h00);
                wait_cyc(3);
            end
        end
        $display("test preemption done");
        // Reset in mid-run clears the enables again
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        wait_cyc(1);
        axi_rd(ENA_ADDR, d, r);
        chk(d & 32'hbf, 32'h0, "enable after reset");
        $display("test reset done");
        end_sim();
    end
endmodule
`default_nettype wire
